// File: serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// Register byte offsets on the AHB-Lite bus.
`define RX_DATA_OFFSET 8'h00
`define TX_DATA_OFFSET 8'h04
`define PORT_CONTROL_OFFSET 8'h08

// Field positions inside port_control_reg.
`define CTL_RX_EN 0
`define CTL_RX_READY 1
`define CTL_RX_OVERRUN 2
`define CTL_RX_SYNC_ERR 3
`define CTL_RX_IRQ_MODE 4
`define CTL_RX_FIG 6
`define CTL_RX_DLY 7
`define CTL_RX_WIDE 9
`define CTL_TX_EN 16
`define CTL_TX_READY 17
`define CTL_TX_EMPTY_N 18
`define CTL_TX_SYNC_ERR 19
`define CTL_TX_IRQ_MODE 20
`define CTL_TX_FIG 22
`define CTL_TX_DLY 23
`define CTL_TX_WIDE 25

// Bits of port_control_reg held as plain storage, and its reset value.
`define CTL_WRITE_MASK 32'h03F1_03F1
`define PORT_CONTROL_RESET 32'h0000_0000

// Interrupt mode codes.
`define IRQ_MODE_READY 2'h0
`define IRQ_MODE_SYNC_ERR 2'h3

// Element lengths in bits.
`define ELEM_SHORT_LEN 6'h08
`define ELEM_LONG_LEN 6'h20

// Pin synchroniser lanes.
`define PIN_RX_CLK 0
`define PIN_RX_FS 1
`define PIN_DIN 2
`define PIN_TX_CLK 3
`define PIN_TX_FS 4

`endif

// File: serial_port_pkg.sv
package serial_port_pkg;

    typedef enum logic [1:0] {
        LANE_IDLE,
        LANE_SHIFT,
        LANE_HALT
    } lane_state_t;

    typedef struct packed {
        logic [4:0] pin_meta;
        logic [4:0] pin_sync;
        logic rx_clk_prev;
        logic tx_clk_prev;
        logic rx_fs_prev;
        logic tx_fs_prev;
        logic [31:0] ctrl;
        lane_state_t rx_state;
        logic [5:0] rx_cnt;
        logic [1:0] rx_start;
        logic [31:0] rx_shift_reg;
        logic [31:0] rx_buffer_reg;
        logic [31:0] rx_data_reg;
        logic rx_buf_full;
        logic rx_ready_flag;
        logic rx_overrun_flag;
        logic rx_sync_error_flag;
        lane_state_t tx_state;
        logic [5:0] tx_cnt;
        logic [1:0] tx_start;
        logic [31:0] tx_data_reg;
        logic [31:0] tx_shift_reg;
        logic tx_full;
        logic tx_ready_flag;
        logic tx_empty_n_flag;
        logic tx_sync_error_flag;
        logic tx_bit;
        logic tx_out;
        logic ahb_write;
        logic [7:0] ahb_addr;
        logic [31:0] hrdata;
    } port_state_t;

endpackage

// File: serial_port_sync_error_logic.sv
// Function
// - Early frame sync by data delay is unexpected.
// - Frame ignore set skips unexpected syncs entirely.
// - Receive: discard shift, flag error, restart element.
// - Transmit: abort, flag error, resend same element.
// - Overrun when data, buffer, shift all full.
// - Shift-to-buffer move only after buffer drained.
// - No overrun before three received elements.
// - Data read or resets clear the overrun.
// - After overrun clear, wait for new sync.
// - First syncs and interpacket syncs are normal.
// - Sync data-delay clocks early is valid start.
// - Receive sync error sticky until reset or zero.
// - Receive interrupt mode 11b follows sync error.
// - Writing one sets receive sync error.
// - Second transmit write replaces unsent value.
// - Transmit interrupt mode 00b follows ready.
// - Transmit empty flag is active low.
// - Frame ignore packs short frames into words.
// - Transmit sync error sticky, mode 11b interrupts.
// - Underflow resends previous value each sync.
`timescale 1ns/100ps
`include "serial_port_defs.svh"

module serial_port_sync_error_logic (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RX_BIT_CLOCK,
    input wire logic RX_FRAME_SYNC,
    input wire logic SERIAL_IN,
    input wire logic TX_BIT_CLOCK,
    input wire logic TX_FRAME_SYNC,
    output logic SERIAL_OUT,
    output logic RX_IRQ,
    output logic TX_IRQ,
    output logic TX_DMA_EVENT
);

    serial_port_pkg::port_state_t r;
    serial_port_pkg::port_state_t next_r;

    function automatic logic [5:0] elem_len(input logic wide);
        return wide ? `ELEM_LONG_LEN : `ELEM_SHORT_LEN;
    endfunction

    // Bits still due after the current one when a sync arrives.
    function automatic logic early_sync(input logic [5:0] done, input logic wide,
                                        input logic [1:0] dly);
        logic [5:0] left;
        left = elem_len(wide) - done;
        return left >= {4'h0, dly};
    endfunction

    function automatic logic irq_select(input logic [1:0] mode, input logic ready,
                                        input logic sync_err);
        logic sel;
        sel = 1'b0;
        if (mode == `IRQ_MODE_READY) begin
            sel = ready;
        end else if (mode == `IRQ_MODE_SYNC_ERR) begin
            sel = sync_err;
        end
        return sel;
    endfunction

    logic rx_fall;
    logic tx_fall;
    logic tx_rise;
    logic rx_fs_pulse;
    logic tx_fs_pulse;
    logic rx_accept;
    logic rx_abort;
    logic tx_accept;
    logic tx_abort;
    logic rx_begin;
    logic tx_begin;
    logic [5:0] tx_index;
    logic ahb_take;

    always_comb begin
        next_r = r;
        rx_accept = 1'b0;
        rx_abort = 1'b0;
        tx_accept = 1'b0;
        tx_abort = 1'b0;
        rx_begin = 1'b0;
        tx_begin = 1'b0;
        tx_index = 6'h00;

        // Two-flop synchronisers on every pin, then edge detection on stage two.
        next_r.pin_meta = {TX_FRAME_SYNC, TX_BIT_CLOCK, SERIAL_IN, RX_FRAME_SYNC,
                           RX_BIT_CLOCK};
        next_r.pin_sync = r.pin_meta;
        next_r.rx_clk_prev = r.pin_sync[`PIN_RX_CLK];
        next_r.tx_clk_prev = r.pin_sync[`PIN_TX_CLK];
        rx_fall = r.rx_clk_prev && !r.pin_sync[`PIN_RX_CLK];
        tx_fall = r.tx_clk_prev && !r.pin_sync[`PIN_TX_CLK];
        tx_rise = !r.tx_clk_prev && r.pin_sync[`PIN_TX_CLK];
        rx_fs_pulse = rx_fall && r.pin_sync[`PIN_RX_FS] && !r.rx_fs_prev;
        tx_fs_pulse = tx_fall && r.pin_sync[`PIN_TX_FS] && !r.tx_fs_prev;

        // Bus address phase: capture it and serve the read data at once.
        ahb_take = HSEL && HTRANS[1] && HREADY;
        next_r.ahb_write = ahb_take && HWRITE;
        next_r.ahb_addr = HADDR[7:0];
        if (ahb_take && !HWRITE) begin
            case (HADDR[7:0])
                `RX_DATA_OFFSET: begin
                    next_r.hrdata = r.rx_data_reg;
                    next_r.rx_ready_flag = 1'b0;
                    if (r.rx_overrun_flag) begin
                        next_r.rx_overrun_flag = 1'b0;
                        next_r.rx_state = serial_port_pkg::LANE_HALT;
                        next_r.rx_start = 2'h0;
                    end
                end
                `TX_DATA_OFFSET: begin
                    next_r.hrdata = r.tx_data_reg;
                end
                `PORT_CONTROL_OFFSET: begin
                    next_r.hrdata = r.ctrl;
                    next_r.hrdata[`CTL_RX_READY] = r.rx_ready_flag;
                    next_r.hrdata[`CTL_RX_OVERRUN] = r.rx_overrun_flag;
                    next_r.hrdata[`CTL_RX_SYNC_ERR] = r.rx_sync_error_flag;
                    next_r.hrdata[`CTL_TX_READY] = r.tx_ready_flag;
                    next_r.hrdata[`CTL_TX_EMPTY_N] = r.tx_empty_n_flag;
                    next_r.hrdata[`CTL_TX_SYNC_ERR] = r.tx_sync_error_flag;
                end
                default: begin
                    next_r.hrdata = 32'h0000_0000;
                end
            endcase
        end

        // Bus data phase of a write.
        if (r.ahb_write) begin
            case (r.ahb_addr)
                `TX_DATA_OFFSET: begin
                    next_r.tx_data_reg = HWDATA;
                    next_r.tx_full = 1'b1;
                    next_r.tx_ready_flag = 1'b0;
                end
                `PORT_CONTROL_OFFSET: begin
                    next_r.ctrl = HWDATA & `CTL_WRITE_MASK;
                    next_r.rx_sync_error_flag = HWDATA[`CTL_RX_SYNC_ERR];
                    next_r.tx_sync_error_flag = HWDATA[`CTL_TX_SYNC_ERR];
                end
                default: begin
                end
            endcase
        end

        // Buffer to data register copy whenever the data register is free.
        // A read frees the data register one cycle before the buffer refills it.
        if (next_r.rx_buf_full && !r.rx_ready_flag && !next_r.rx_ready_flag) begin
            next_r.rx_data_reg = next_r.rx_buffer_reg;
            next_r.rx_buf_full = 1'b0;
            next_r.rx_ready_flag = 1'b1;
        end

        // Receive section, acting on falling edges of its bit clock.
        if (rx_fall) begin
            next_r.rx_fs_prev = r.pin_sync[`PIN_RX_FS];
            if (rx_fs_pulse) begin
                case (r.rx_state)
                    serial_port_pkg::LANE_SHIFT: begin
                        if (!early_sync(r.rx_cnt + 6'h01, r.ctrl[`CTL_RX_WIDE],
                                        r.ctrl[`CTL_RX_DLY +: 2])) begin
                            rx_accept = 1'b1;
                        end else if (!r.ctrl[`CTL_RX_FIG]) begin
                            rx_accept = 1'b1;
                            rx_abort = 1'b1;
                        end
                    end
                    default: begin
                        rx_accept = 1'b1;
                    end
                endcase
            end
            if (rx_abort) begin
                next_r.rx_sync_error_flag = 1'b1;
                next_r.rx_state = serial_port_pkg::LANE_IDLE;
            end
            if (rx_accept && r.ctrl[`CTL_RX_DLY +: 2] == 2'h0) begin
                rx_begin = 1'b1;
                next_r.rx_start = 2'h0;
            end else if (rx_accept) begin
                next_r.rx_start = r.ctrl[`CTL_RX_DLY +: 2];
            end else if (r.rx_start != 2'h0) begin
                rx_begin = r.rx_start == 2'h1;
                next_r.rx_start = r.rx_start - 2'h1;
            end
            if (rx_begin) begin
                next_r.rx_shift_reg = {31'h0000_0000, r.pin_sync[`PIN_DIN]};
                next_r.rx_cnt = 6'h01;
                next_r.rx_state = serial_port_pkg::LANE_SHIFT;
            end else if (next_r.rx_state == serial_port_pkg::LANE_SHIFT) begin
                next_r.rx_shift_reg = {r.rx_shift_reg[30:0], r.pin_sync[`PIN_DIN]};
                next_r.rx_cnt = r.rx_cnt + 6'h01;
            end
            if (next_r.rx_state == serial_port_pkg::LANE_SHIFT &&
                next_r.rx_cnt == elem_len(r.ctrl[`CTL_RX_WIDE])) begin
                next_r.rx_state = serial_port_pkg::LANE_IDLE;
                if (!next_r.rx_buf_full) begin
                    next_r.rx_buffer_reg = next_r.rx_shift_reg;
                    next_r.rx_buf_full = 1'b1;
                end else if (next_r.rx_ready_flag) begin
                    next_r.rx_overrun_flag = 1'b1;
                end
            end
        end

        // Transmit section: decisions on falling edges, pin update on rising edges.
        if (tx_fall) begin
            next_r.tx_fs_prev = r.pin_sync[`PIN_TX_FS];
            if (tx_fs_pulse) begin
                case (r.tx_state)
                    serial_port_pkg::LANE_SHIFT: begin
                        if (!early_sync(r.tx_cnt + 6'h01, r.ctrl[`CTL_TX_WIDE],
                                        r.ctrl[`CTL_TX_DLY +: 2])) begin
                            tx_accept = 1'b1;
                        end else if (!r.ctrl[`CTL_TX_FIG]) begin
                            tx_accept = 1'b1;
                            tx_abort = 1'b1;
                        end
                    end
                    default: begin
                        tx_accept = 1'b1;
                    end
                endcase
            end
            if (tx_abort) begin
                next_r.tx_sync_error_flag = 1'b1;
                next_r.tx_state = serial_port_pkg::LANE_IDLE;
            end else if (tx_accept && next_r.tx_full) begin
                next_r.tx_shift_reg = next_r.tx_data_reg;
                next_r.tx_full = 1'b0;
                next_r.tx_ready_flag = 1'b1;
                next_r.tx_empty_n_flag = 1'b1;
            end
            if (tx_accept && r.ctrl[`CTL_TX_DLY +: 2] == 2'h0) begin
                tx_begin = 1'b1;
                next_r.tx_start = 2'h0;
            end else if (tx_accept) begin
                next_r.tx_start = r.ctrl[`CTL_TX_DLY +: 2];
            end else if (r.tx_start != 2'h0) begin
                tx_begin = r.tx_start == 2'h1;
                next_r.tx_start = r.tx_start - 2'h1;
            end
            if (tx_begin) begin
                tx_index = elem_len(r.ctrl[`CTL_TX_WIDE]) - 6'h01;
                next_r.tx_bit = next_r.tx_shift_reg[tx_index[4:0]];
                next_r.tx_cnt = 6'h01;
                next_r.tx_state = serial_port_pkg::LANE_SHIFT;
            end else if (next_r.tx_state == serial_port_pkg::LANE_SHIFT) begin
                if (r.tx_cnt == elem_len(r.ctrl[`CTL_TX_WIDE])) begin
                    next_r.tx_state = serial_port_pkg::LANE_IDLE;
                    next_r.tx_bit = 1'b0;
                    if (!next_r.tx_full) begin
                        next_r.tx_empty_n_flag = 1'b0;
                    end
                end else begin
                    tx_index = elem_len(r.ctrl[`CTL_TX_WIDE]) - 6'h01 - r.tx_cnt;
                    next_r.tx_bit = r.tx_shift_reg[tx_index[4:0]];
                    next_r.tx_cnt = r.tx_cnt + 6'h01;
                end
            end
        end
        if (tx_rise) begin
            next_r.tx_out = r.tx_bit;
        end

        // Section resets hold each half idle with its flags cleared, except transmit ready, which is held set.
        if (!next_r.ctrl[`CTL_RX_EN]) begin
            next_r.rx_state = serial_port_pkg::LANE_IDLE;
            next_r.rx_start = 2'h0;
            next_r.rx_cnt = 6'h00;
            next_r.rx_buf_full = 1'b0;
            next_r.rx_ready_flag = 1'b0;
            next_r.rx_overrun_flag = 1'b0;
            next_r.rx_sync_error_flag = 1'b0;
        end
        if (!next_r.ctrl[`CTL_TX_EN]) begin
            next_r.tx_state = serial_port_pkg::LANE_IDLE;
            next_r.tx_start = 2'h0;
            next_r.tx_cnt = 6'h00;
            next_r.tx_shift_reg = 32'h0000_0000;
            next_r.tx_full = 1'b0;
            next_r.tx_ready_flag = 1'b1;
            next_r.tx_empty_n_flag = 1'b0;
            next_r.tx_sync_error_flag = 1'b0;
            next_r.tx_bit = 1'b0;
            next_r.tx_out = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
            r.ctrl <= `PORT_CONTROL_RESET;
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign HRDATA = r.hrdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign SERIAL_OUT = r.tx_out;
    assign RX_IRQ = irq_select(r.ctrl[`CTL_RX_IRQ_MODE +: 2], r.rx_ready_flag,
                               r.rx_sync_error_flag);
    assign TX_IRQ = irq_select(r.ctrl[`CTL_TX_IRQ_MODE +: 2], r.tx_ready_flag,
                               r.tx_sync_error_flag);
    assign TX_DMA_EVENT = r.tx_ready_flag && r.ctrl[`CTL_TX_EN];

endmodule // serial_port_sync_error_logic

// File: serial_port_checker_props.sv
`timescale 1ns/100ps
module port_checker (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic SERIAL_OUT,
    input wire logic RX_IRQ,
    input wire logic TX_IRQ,
    input wire logic TX_DMA_EVENT
);
    logic take;
    logic wr_ph;
    logic rd_ctl;
    logic [7:0] adr;
    logic [31:0] shd;
    assign take = HSEL && HTRANS[1] && HREADY && CE;
    // Shadow of the control word, taken from bus writes.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ph <= 1'b0;
            rd_ctl <= 1'b0;
            adr <= 8'h00;
            shd <= 32'h0000_0000;
        end else begin
            wr_ph <= take && HWRITE;
            rd_ctl <= take && !HWRITE && HADDR[7:0] == 8'h08;
            adr <= HADDR[7:0];
            if (wr_ph && CE && adr == 8'h08) begin
                shd <= HWDATA;
            end
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    unmapped_zero_a:
        assert property (take && !HWRITE && HADDR == 32'h0000_000C |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a:
        assert property (!(take && !HWRITE) |=> $stable(HRDATA))
        else $error("read data moved without a read");
    ctl_store_a:
        assert property (rd_ctl |-> (HRDATA & 32'h03F1_03F1) == (shd & 32'h03F1_03F1)
            && (HRDATA & 32'hFC00_FC00) == 32'h0)
        else $error("control storage bits differ");
    rx_err_irq_a:
        assert property (rd_ctl && HRDATA[5:4] == 2'h3 |-> RX_IRQ == HRDATA[3])
        else $error("receive irq not from sync error");
    tx_err_irq_a:
        assert property (rd_ctl && HRDATA[21:20] == 2'h3 |-> TX_IRQ == HRDATA[19])
        else $error("transmit irq not from sync error");
    tx_rdy_irq_a:
        assert property (rd_ctl && HRDATA[21:20] == 2'h0 |-> TX_IRQ == HRDATA[17])
        else $error("transmit irq not from ready");
    read_clears_a:
        assert property (take && !HWRITE && HADDR[7:0] == 8'h00 && shd[5:4] == 2'h0
            |=> !RX_IRQ)
        else $error("data read left ready set");
    tx_write_busy_a:
        assert property (wr_ph && CE && adr == 8'h04 && shd[16] && shd[21:20] == 2'h0
            |=> !TX_IRQ && !TX_DMA_EVENT)
        else $error("transmit write left ready set");
    dma_event_a:
        assert property (shd[21:20] == 2'h0 |-> TX_DMA_EVENT == (TX_IRQ && shd[16]))
        else $error("dma event not ready and enable");
    tx_off_quiet_a:
        assert property (!shd[16] [*2] |-> !SERIAL_OUT)
        else $error("serial output active in reset");
    cover property (rd_ctl && HRDATA[2]);
    cover property (rd_ctl && HRDATA[3] && HRDATA[19]);
    cover property (rd_ctl && HRDATA[6] && HRDATA[9]);
endmodule // port_checker

// File: serial_far_end.sv
`timescale 1ns/100ps
module serial_far_end (
    input wire logic serial_out,
    output logic bit_clk,
    output logic frame_sync,
    output logic data_out
);
    logic [1:0] q[$];
    logic got[$];
    logic [1:0] it;
    // The bit clock runs only while slots are queued; sync and data move at its rise.
    initial begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        data_out = 1'b0;
        forever begin
            if (q.size() == 0) begin
                frame_sync = 1'b0;
                data_out = ~data_out;
                while (q.size() == 0) #5;
            end
            it = q.pop_front();
            frame_sync = it[1];
            data_out = it[0];
            bit_clk = 1'b1;
            #40;
            bit_clk = 1'b0;
            #39;
            got.push_back(serial_out);
            #1;
        end
    end
endmodule // serial_far_end

// File: serial_port_sync_error_logic_tb.sv
`timescale 1ns/100ps
module serial_port_sync_error_logic_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp, sout, rx_irq, tx_irq, dma_ev, bclk, fsync, din;
    logic [31:0] rd, a, b, c, d;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int slot = 0;
    int s0 = 0;
    always #5 mclk = ~mclk;
    serial_port_sync_error_logic u_serial_port_sync_error_logic (
        .MCLK(mclk), .RESET_N(reset_n), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .RX_BIT_CLOCK(bclk), .RX_FRAME_SYNC(fsync),
        .SERIAL_IN(din), .TX_BIT_CLOCK(bclk), .TX_FRAME_SYNC(fsync), .SERIAL_OUT(sout),
        .RX_IRQ(rx_irq), .TX_IRQ(tx_irq), .TX_DMA_EVENT(dma_ev));
    serial_far_end u_serial_far_end (.serial_out(sout), .bit_clk(bclk), .frame_sync(fsync),
        .data_out(din));
    task automatic close_out();
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, ad};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dt;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic rdx(input logic [31:0] e);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, e);
    endtask
    task automatic rdc(input logic [31:0] e);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, e);
    endtask
    task automatic put(input logic f, input logic v);
        u_serial_far_end.q.push_back({f, v});
        slot++;
    endtask
    task automatic lead();
        s0 = slot;
        put(1'b1, 1'($urandom));
    endtask
    task automatic bits(input logic [31:0] v, input int n, input int s);
        for (int i = n - 1; i >= 0; i--) begin
            put(i == n - 1 - s, v[i]);
        end
    endtask
    task automatic drain();
        put(1'b0, 1'($urandom));
        put(1'b0, 1'($urandom));
        while (u_serial_far_end.got.size() < slot) @(posedge mclk);
        repeat (10) @(posedge mclk);
    endtask
    function automatic logic [31:0] seen(input int s, input int n);
        seen = 32'h0;
        for (int i = 0; i < n; i++) begin
            seen = {seen[30:0], u_serial_far_end.got[s + i]};
        end
    endfunction
    task automatic tx_is(input int s, input int n, input logic [31:0] e);
        chk(seen(s + 2, n), e);
    endtask
    initial begin
        rd = $urandom(32'h912A);
        a = $urandom;
        b = $urandom;
        c = $urandom;
        d = $urandom;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdc(32'h0002_0000);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h08, 32'h0081_0081);
        bus(1'b1, 8'h04, c);
        bus(1'b1, 8'h04, d);
        lead();
        bits(a, 8, 7);
        bits(b, 8, -1);
        drain();
        tx_is(s0, 8, {24'h0, d[7:0]});
        tx_is(s0 + 8, 8, {24'h0, d[7:0]});
        rdc(32'h0083_0083);
        rdx({24'h0, a[7:0]});
        rdx({24'h0, b[7:0]});
        lead();
        bits(a, 8, 7);
        bits(b, 8, -1);
        drain();
        rdc(32'h0083_0083);
        lead();
        bits(c, 8, -1);
        drain();
        rdc(32'h0083_0087);
        rdx({24'h0, a[7:0]});
        rdc(32'h0083_0083);
        rdx({24'h0, b[7:0]});
        bits(c, 8, -1);
        lead();
        bits(d, 8, -1);
        drain();
        rdx({24'h0, d[7:0]});
        bus(1'b1, 8'h08, 32'h00B1_00B1);
        bus(1'b1, 8'h04, c);
        lead();
        bits(a, 4, 3);
        bits(b, 8, -1);
        drain();
        tx_is(s0 + 4, 8, {24'h0, c[7:0]});
        rdx({24'h0, b[7:0]});
        rdc(32'h00BB_00B9);
        chk({31'h0, rx_irq}, 32'h1);
        bus(1'b1, 8'h08, 32'h00B1_00B1);
        rdc(32'h00B3_00B1);
        bus(1'b1, 8'h08, 32'h00B1_00B9);
        rdc(32'h00B3_00B9);
        bus(1'b1, 8'h08, 32'h00C1_00C1);
        bus(1'b1, 8'h04, d);
        lead();
        bits(a, 8, 3);
        drain();
        rdx({24'h0, a[7:0]});
        rdc(32'h00C3_00C1);
        tx_is(s0, 8, {24'h0, d[7:0]});
        bus(1'b1, 8'h08, 32'h02C1_02C1);
        bus(1'b1, 8'h04, c);
        lead();
        for (int k = 3; k >= 0; k--) bits(b >> (8 * k), 8, k > 0 ? 7 : -1);
        drain();
        rdx(b);
        tx_is(s0, 32, c);
        close_out();
    end
endmodule // serial_port_sync_error_logic_tb
bind serial_port_sync_error_logic port_checker u_port_checker (.MCLK(MCLK), .RESET_N(RESET_N),
    .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .SERIAL_OUT(SERIAL_OUT), .RX_IRQ(RX_IRQ),
    .TX_IRQ(TX_IRQ), .TX_DMA_EVENT(TX_DMA_EVENT));
